// ---- rtl/ddp_pkg.sv ----
// package: register map, status layout, state codes and carrier types of the descriptor dma
package ddp_pkg;
    // ******************************
    // register offsets
    // ******************************
    localparam logic [7:0] TX_POLL_OFS = 8'h08;
    localparam logic [7:0] RX_POLL_OFS = 8'h10;
    localparam logic [7:0] RX_BASE_OFS = 8'h18;
    localparam logic [7:0] TX_BASE_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h28;
    localparam logic [7:0] CTRL_OFS = 8'h30;
    localparam logic [7:0] MASK_OFS = 8'h38;
    // ******************************
    // reset values
    // ******************************
    localparam logic [31:0] POLL_RST = 32'hffff_ffff;
    localparam logic [29:0] BASE_RST = 30'h0000_0000;
    localparam logic [16:0] MASK_RST = 17'h0_0000;
    // ******************************
    // field positions
    // ******************************
    localparam int ST_TCI = 0;
    localparam int ST_TPS = 1;
    localparam int ST_TDU = 2;
    localparam int ST_RCI = 6;
    localparam int ST_RDU = 7;
    localparam int ST_RPS = 8;
    localparam int ST_FBF = 13;
    localparam int ST_AIS = 15;
    localparam int ST_NIS = 16;
    localparam int ST_RXS = 17;
    localparam int ST_TXS = 20;
    localparam int ST_BEK = 23;
    localparam int CTRL_TX_RUN = 0;
    localparam int CTRL_RX_RUN = 1;
    localparam int CTRL_SRST = 2;
    localparam logic [13:0] NORM_EVENTS = 14'h0045;
    localparam logic [13:0] ABN_EVENTS = 14'h2182;
    // ******************************
    // state codes
    // ******************************
    localparam logic [2:0] TXC_STOP = 3'h0;
    localparam logic [2:0] TXC_FETCH = 3'h1;
    localparam logic [2:0] TXC_XMIT = 3'h2;
    localparam logic [2:0] TXC_FILL = 3'h3;
    localparam logic [2:0] TXC_SUSP = 3'h6;
    localparam logic [2:0] TXC_WB = 3'h7;
    localparam logic [2:0] RXC_STOP = 3'h0;
    localparam logic [2:0] RXC_FETCH = 3'h1;
    localparam logic [2:0] RXC_CHECK = 3'h2;
    localparam logic [2:0] RXC_WAIT = 3'h3;
    localparam logic [2:0] RXC_SUSP = 3'h4;
    localparam logic [2:0] RXC_WB = 3'h5;
    localparam logic [2:0] RXC_FLUSH = 3'h6;
    localparam logic [2:0] RXC_DRAIN = 3'h7;
    // ******************************
    // types
    // ******************************
    typedef enum logic [2:0] {TX_STOP, TX_FETCH, TX_FILL, TX_XMIT, TX_WB, TX_SUSP} ddp_tx_e;
    typedef enum logic [2:0] {
        RX_STOP, RX_FETCH, RX_WAIT, RX_DRAIN, RX_CHECK, RX_WB, RX_SUSP, RX_FLUSH
    } ddp_rx_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ddp_bus_req_s;
    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
    } ddp_mem_req_s;
    typedef struct packed {
        logic ack;
        logic own;
    } ddp_mem_rsp_s;
    typedef struct packed {
        ddp_tx_e tx_st;
        ddp_rx_e rx_st;
        logic [31:0] tx_poll;
        logic [31:0] rx_poll;
        logic [29:0] tx_base;
        logic [29:0] rx_base;
        logic [29:0] tx_cur;
        logic [29:0] rx_cur;
        logic tx_run;
        logic rx_run;
        logic bus_off;
        logic [13:0] ev;
        logic [2:0] err_kind;
        logic [16:0] mask;
        logic [31:0] rdata;
        logic irq;
        ddp_mem_req_s tx_mem;
        ddp_mem_req_s rx_mem;
    } ddp_state_s;
endpackage

// ---- rtl/ddp_dma.sv ----
// module: descriptor dma poll, ring base, engine state and status logic
//
// Chosen here: the plain strobed port.

// Overview of operation
// - Tx poll write in suspend refetches descriptor; owned resumes.
// - Rx poll write in suspend refetches descriptor; owned resumes.
// - Rx ring start held in bits 31:2; fetch starts there.
// - Tx ring start held in bits 31:2; fetch starts there.
// - Ring base bits 1:0 read zero, forcing alignment.
// - Status 25:23 hold bus error kind, valid while fault set.
// - Bus error kind never raises an interrupt.
// - Status bits 31:26 reserved, read zero.
// - Status 22:20 report tx state code; no interrupt.
// - Status 19:17 report rx state code.
// - Event flags latch high until software clears them.
// - Bus fault sets fault flag, blocks bus until soft reset.
module ddp_dma #(
    parameter int DESC_BYTES = 16
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire ddp_pkg::ddp_bus_req_s i_bus,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output ddp_pkg::ddp_mem_req_s o_tx_mem,
    input wire ddp_pkg::ddp_mem_rsp_s i_tx_mem,
    output ddp_pkg::ddp_mem_req_s o_rx_mem,
    input wire ddp_pkg::ddp_mem_rsp_s i_rx_mem,
    input wire logic i_tx_fill_done,
    input wire logic i_tx_frame_done,
    input wire logic i_rx_frame_start,
    input wire logic i_rx_frame_end,
    input wire logic i_bus_err,
    input wire logic [2:0] i_bus_err_kind
);
    localparam logic [29:0] DESC_STEP = 30'(DESC_BYTES / 4);

    if (DESC_BYTES < 4 || DESC_BYTES % 4 != 0) begin : g_chk
        $error("DESC_BYTES must be a positive multiple of 4");
    end

    // ******************************
    // state code mapping
    // ******************************
    function automatic logic [2:0] tx_code(input ddp_pkg::ddp_tx_e s);
        logic [2:0] c;
        c = ddp_pkg::TXC_STOP;
        unique case (s)
            ddp_pkg::TX_STOP: c = ddp_pkg::TXC_STOP;
            ddp_pkg::TX_FETCH: c = ddp_pkg::TXC_FETCH;
            ddp_pkg::TX_FILL: c = ddp_pkg::TXC_FILL;
            ddp_pkg::TX_XMIT: c = ddp_pkg::TXC_XMIT;
            ddp_pkg::TX_WB: c = ddp_pkg::TXC_WB;
            ddp_pkg::TX_SUSP: c = ddp_pkg::TXC_SUSP;
            default: c = ddp_pkg::TXC_STOP;
        endcase
        return c;
    endfunction

    function automatic logic [2:0] rx_code(input ddp_pkg::ddp_rx_e s);
        logic [2:0] c;
        c = ddp_pkg::RXC_STOP;
        unique case (s)
            ddp_pkg::RX_STOP: c = ddp_pkg::RXC_STOP;
            ddp_pkg::RX_FETCH: c = ddp_pkg::RXC_FETCH;
            ddp_pkg::RX_WAIT: c = ddp_pkg::RXC_WAIT;
            ddp_pkg::RX_DRAIN: c = ddp_pkg::RXC_DRAIN;
            ddp_pkg::RX_CHECK: c = ddp_pkg::RXC_CHECK;
            ddp_pkg::RX_WB: c = ddp_pkg::RXC_WB;
            ddp_pkg::RX_SUSP: c = ddp_pkg::RXC_SUSP;
            ddp_pkg::RX_FLUSH: c = ddp_pkg::RXC_FLUSH;
        endcase
        return c;
    endfunction

    function automatic logic wr_hit(input ddp_pkg::ddp_bus_req_s b, input logic [7:0] ofs);
        return b.wr && b.addr == ofs;
    endfunction

    ddp_pkg::ddp_state_s state_reg;
    ddp_pkg::ddp_state_s state_next;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        logic [13:0] ev_set;
        logic [13:0] ev_clr;
        logic [31:0] status;
        logic srst;
        ev_set = '0;
        ev_clr = '0;
        state_next = state_reg;
        state_next.rdata = '0;
        srst = wr_hit(i_bus, ddp_pkg::CTRL_OFS) && i_bus.wdata[ddp_pkg::CTRL_SRST];

        // status image
        status = '0;
        status[ddp_pkg::ST_BEK +: 3] = state_reg.err_kind;
        status[ddp_pkg::ST_TXS +: 3] = tx_code(state_reg.tx_st);
        status[ddp_pkg::ST_RXS +: 3] = rx_code(state_reg.rx_st);
        status[ddp_pkg::ST_NIS] = |(state_reg.ev & ddp_pkg::NORM_EVENTS);
        status[ddp_pkg::ST_AIS] = |(state_reg.ev & ddp_pkg::ABN_EVENTS);
        status[13:0] = state_reg.ev;

        // register writes
        if (wr_hit(i_bus, ddp_pkg::TX_POLL_OFS)) begin
            state_next.tx_poll = i_bus.wdata;
        end
        if (wr_hit(i_bus, ddp_pkg::RX_POLL_OFS)) begin
            state_next.rx_poll = i_bus.wdata;
        end
        if (wr_hit(i_bus, ddp_pkg::RX_BASE_OFS)) begin
            state_next.rx_base = i_bus.wdata[31:2];
        end
        if (wr_hit(i_bus, ddp_pkg::TX_BASE_OFS)) begin
            state_next.tx_base = i_bus.wdata[31:2];
        end
        if (wr_hit(i_bus, ddp_pkg::CTRL_OFS)) begin
            state_next.tx_run = i_bus.wdata[ddp_pkg::CTRL_TX_RUN];
            state_next.rx_run = i_bus.wdata[ddp_pkg::CTRL_RX_RUN];
        end
        if (wr_hit(i_bus, ddp_pkg::MASK_OFS)) begin
            state_next.mask = i_bus.wdata[16:0];
        end
        if (wr_hit(i_bus, ddp_pkg::STATUS_OFS)) begin
            ev_clr = i_bus.wdata[13:0];
        end

        // register reads
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                ddp_pkg::TX_POLL_OFS: state_next.rdata = state_reg.tx_poll;
                ddp_pkg::RX_POLL_OFS: state_next.rdata = state_reg.rx_poll;
                ddp_pkg::RX_BASE_OFS: state_next.rdata = {state_reg.rx_base, 2'b00};
                ddp_pkg::TX_BASE_OFS: state_next.rdata = {state_reg.tx_base, 2'b00};
                ddp_pkg::STATUS_OFS: begin
                    state_next.rdata = status;
                    ev_clr = '1;
                end
                ddp_pkg::CTRL_OFS: state_next.rdata = {30'h0000_0000, state_reg.rx_run,
                    state_reg.tx_run};
                ddp_pkg::MASK_OFS: state_next.rdata = {15'h0000, state_reg.mask};
                default: state_next.rdata = '0;
            endcase
        end

        // transmit engine
        unique case (state_reg.tx_st)
            ddp_pkg::TX_STOP: begin
                if (state_reg.tx_run && !state_reg.bus_off) begin
                    state_next.tx_cur = state_reg.tx_base;
                    state_next.tx_st = ddp_pkg::TX_FETCH;
                end
            end
            ddp_pkg::TX_FETCH: begin
                if (i_tx_mem.ack) begin
                    if (i_tx_mem.own) begin
                        state_next.tx_st = ddp_pkg::TX_FILL;
                    end else begin
                        state_next.tx_st = ddp_pkg::TX_SUSP;
                        ev_set[ddp_pkg::ST_TDU] = 1'b1;
                    end
                end
            end
            ddp_pkg::TX_FILL: begin
                if (i_tx_fill_done) begin
                    state_next.tx_st = ddp_pkg::TX_XMIT;
                end
            end
            ddp_pkg::TX_XMIT: begin
                if (i_tx_frame_done) begin
                    state_next.tx_st = ddp_pkg::TX_WB;
                end
            end
            ddp_pkg::TX_WB: begin
                if (i_tx_mem.ack) begin
                    state_next.tx_cur = state_reg.tx_cur + DESC_STEP;
                    state_next.tx_st = ddp_pkg::TX_FETCH;
                    ev_set[ddp_pkg::ST_TCI] = 1'b1;
                end
            end
            ddp_pkg::TX_SUSP: begin
                // a poll elsewhere is simply stored
                if (wr_hit(i_bus, ddp_pkg::TX_POLL_OFS)) begin
                    state_next.tx_st = ddp_pkg::TX_FETCH;
                end
            end
        endcase
        if (!state_reg.tx_run && state_reg.tx_st != ddp_pkg::TX_STOP) begin
            state_next.tx_st = ddp_pkg::TX_STOP;
            ev_set[ddp_pkg::ST_TPS] = 1'b1;
        end

        // receive engine
        unique case (state_reg.rx_st)
            ddp_pkg::RX_STOP: begin
                if (state_reg.rx_run && !state_reg.bus_off) begin
                    state_next.rx_cur = state_reg.rx_base;
                    state_next.rx_st = ddp_pkg::RX_FETCH;
                end
            end
            ddp_pkg::RX_FETCH: begin
                if (i_rx_mem.ack) begin
                    if (i_rx_mem.own) begin
                        state_next.rx_st = ddp_pkg::RX_WAIT;
                    end else begin
                        state_next.rx_st = ddp_pkg::RX_SUSP;
                        ev_set[ddp_pkg::ST_RDU] = 1'b1;
                    end
                end
            end
            ddp_pkg::RX_WAIT: begin
                if (i_rx_frame_start) begin
                    state_next.rx_st = ddp_pkg::RX_DRAIN;
                end
            end
            ddp_pkg::RX_DRAIN: begin
                if (i_rx_frame_end) begin
                    state_next.rx_st = ddp_pkg::RX_CHECK;
                end
            end
            ddp_pkg::RX_CHECK: state_next.rx_st = ddp_pkg::RX_WB;
            ddp_pkg::RX_WB: begin
                if (i_rx_mem.ack) begin
                    state_next.rx_cur = state_reg.rx_cur + DESC_STEP;
                    state_next.rx_st = ddp_pkg::RX_FETCH;
                    ev_set[ddp_pkg::ST_RCI] = 1'b1;
                end
            end
            ddp_pkg::RX_SUSP: begin
                if (wr_hit(i_bus, ddp_pkg::RX_POLL_OFS)) begin
                    state_next.rx_st = ddp_pkg::RX_FETCH;
                end else if (i_rx_frame_start) begin
                    // no buffer: discard the arriving frame
                    state_next.rx_st = ddp_pkg::RX_FLUSH;
                end
            end
            ddp_pkg::RX_FLUSH: begin
                if (i_rx_frame_end) begin
                    state_next.rx_st = ddp_pkg::RX_SUSP;
                end
            end
        endcase
        if (!state_reg.rx_run && state_reg.rx_st != ddp_pkg::RX_STOP) begin
            state_next.rx_st = ddp_pkg::RX_STOP;
            ev_set[ddp_pkg::ST_RPS] = 1'b1;
        end

        // fatal bus fault halts both engines
        if (i_bus_err && !state_reg.bus_off) begin
            state_next.bus_off = 1'b1;
            state_next.err_kind = i_bus_err_kind;
            state_next.tx_st = ddp_pkg::TX_STOP;
            state_next.rx_st = ddp_pkg::RX_STOP;
            ev_set[ddp_pkg::ST_FBF] = 1'b1;
        end

        // set wins over clear
        state_next.ev = (state_reg.ev & ~ev_clr) | ev_set;

        if (srst) begin
            state_next.bus_off = 1'b0;
            state_next.err_kind = '0;
            state_next.tx_run = 1'b0;
            state_next.rx_run = 1'b0;
            state_next.tx_st = ddp_pkg::TX_STOP;
            state_next.rx_st = ddp_pkg::RX_STOP;
            state_next.ev = '0;
        end

        // memory requests
        state_next.tx_mem.req = !state_next.bus_off && (state_next.tx_st == ddp_pkg::TX_FETCH
            || state_next.tx_st == ddp_pkg::TX_WB);
        state_next.tx_mem.wr = state_next.tx_st == ddp_pkg::TX_WB;
        state_next.tx_mem.addr = {state_next.tx_cur, 2'b00};
        state_next.rx_mem.req = !state_next.bus_off && (state_next.rx_st == ddp_pkg::RX_FETCH
            || state_next.rx_st == ddp_pkg::RX_WB);
        state_next.rx_mem.wr = state_next.rx_st == ddp_pkg::RX_WB;
        state_next.rx_mem.addr = {state_next.rx_cur, 2'b00};

        // kind and state fields stay out of the interrupt
        state_next.irq = |({|(state_next.ev & ddp_pkg::NORM_EVENTS),
            |(state_next.ev & ddp_pkg::ABN_EVENTS), 1'b0, state_next.ev}
            & state_next.mask);
    end

    // ******************************
    // state register
    // ******************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= '0;
            state_reg.tx_st <= ddp_pkg::TX_STOP;
            state_reg.rx_st <= ddp_pkg::RX_STOP;
            state_reg.tx_poll <= ddp_pkg::POLL_RST;
            state_reg.rx_poll <= ddp_pkg::POLL_RST;
            state_reg.tx_base <= ddp_pkg::BASE_RST;
            state_reg.rx_base <= ddp_pkg::BASE_RST;
            state_reg.mask <= ddp_pkg::MASK_RST;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_irq = state_reg.irq;
    assign o_tx_mem = state_reg.tx_mem;
    assign o_rx_mem = state_reg.rx_mem;
endmodule

// ---- tb/ddp_dma_checker.sv ----
// checker: port-level assertions of the descriptor dma, bound to its top module
module ddp_dma_checker #(
    parameter int DESC_BYTES = 16
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire ddp_pkg::ddp_bus_req_s i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic o_irq,
    input wire ddp_pkg::ddp_mem_req_s o_tx_mem,
    input wire ddp_pkg::ddp_mem_rsp_s i_tx_mem,
    input wire ddp_pkg::ddp_mem_req_s o_rx_mem,
    input wire ddp_pkg::ddp_mem_rsp_s i_rx_mem,
    input wire logic i_rx_frame_start,
    input wire logic i_bus_err
);
    // ********
    // suspended-engine tracking
    // ********
    logic tx_susp_reg, rx_susp_reg;
    logic [31:0] tx_addr_reg, rx_addr_reg;
    logic tx_pw, rx_pw, ctl_w;
    assign tx_pw = i_ce && i_bus.wr && i_bus.addr == ddp_pkg::TX_POLL_OFS;
    assign rx_pw = i_ce && i_bus.wr && i_bus.addr == ddp_pkg::RX_POLL_OFS;
    assign ctl_w = i_ce && i_bus.wr && i_bus.addr == ddp_pkg::CTRL_OFS;
    // not-owned fetch parks the engine
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_susp_reg <= 1'b0;
            rx_susp_reg <= 1'b0;
            tx_addr_reg <= 32'h0000_0000;
            rx_addr_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            if (o_tx_mem.req && !o_tx_mem.wr && i_tx_mem.ack && !i_tx_mem.own) begin
                tx_susp_reg <= 1'b1;
                tx_addr_reg <= o_tx_mem.addr;
            end else if (tx_pw || ctl_w || i_bus_err) begin
                tx_susp_reg <= 1'b0;
            end
            if (o_rx_mem.req && !o_rx_mem.wr && i_rx_mem.ack && !i_rx_mem.own) begin
                rx_susp_reg <= 1'b1;
                rx_addr_reg <= o_rx_mem.addr;
            end else if (rx_pw || ctl_w || i_bus_err || i_rx_frame_start) begin
                rx_susp_reg <= 1'b0;
            end
        end
    end
    // ********
    // assertions
    // ********
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    property p_rdata_idle;
        (i_ce && !i_bus.rd) |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero when idle");
    property p_status_rsvd;
        (i_ce && i_bus.rd && i_bus.addr == ddp_pkg::STATUS_OFS) |=> o_rdata[31:26] == 6'h00;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd)
        else $error("reserved status bits set");
    property p_base_align;
        (i_ce && i_bus.rd && (i_bus.addr == ddp_pkg::RX_BASE_OFS
            || i_bus.addr == ddp_pkg::TX_BASE_OFS)) |=> o_rdata[1:0] == 2'h0;
    endproperty
    a_base_align: assert property (p_base_align)
        else $error("ring base low bits set");
    property p_desc_align;
        o_tx_mem.addr[1:0] == 2'h0 && o_rx_mem.addr[1:0] == 2'h0;
    endproperty
    a_desc_align: assert property (p_desc_align)
        else $error("descriptor address unaligned");
    property p_req_hold;
        (i_ce && o_tx_mem.req && !i_tx_mem.ack && !i_bus_err && !i_bus.wr)
            |=> o_tx_mem.req && $stable(o_tx_mem.addr) && $stable(o_tx_mem.wr);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("tx request changed early");
    property p_bus_off;
        (i_ce && i_bus_err) |-> ##2 (!o_tx_mem.req && !o_rx_mem.req) [*3];
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("request after bus fault");
    property p_tx_poll;
        (tx_susp_reg && tx_pw)
            |-> ##[1:2] (o_tx_mem.req && !o_tx_mem.wr && o_tx_mem.addr == tx_addr_reg);
    endproperty
    a_tx_poll: assert property (p_tx_poll)
        else $error("tx poll did not refetch");
    property p_rx_poll;
        (rx_susp_reg && rx_pw)
            |-> ##[1:2] (o_rx_mem.req && !o_rx_mem.wr && o_rx_mem.addr == rx_addr_reg);
    endproperty
    a_rx_poll: assert property (p_rx_poll)
        else $error("rx poll did not refetch");
    property p_irq_rise;
        $rose(o_irq) |-> $past(i_bus_err || i_tx_mem.ack || i_rx_mem.ack || i_bus.wr)
            || $past(i_bus.wr, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose without event");
    property p_irq_fall;
        $fell(o_irq) |-> $past(i_bus.wr || i_bus.rd);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without access");
endmodule
bind ddp_dma ddp_dma_checker #(.DESC_BYTES(DESC_BYTES)) u_ddp_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_tx_mem(o_tx_mem), .i_tx_mem(i_tx_mem),
    .o_rx_mem(o_rx_mem), .i_rx_mem(i_rx_mem), .i_rx_frame_start(i_rx_frame_start),
    .i_bus_err(i_bus_err));

// ---- tb/ddp_mem_model.sv ----
// partner: descriptor memory responder for one dma engine
module ddp_mem_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire ddp_pkg::ddp_mem_req_s i_req,
    input wire logic i_own,
    input wire logic [2:0] i_delay,
    output ddp_pkg::ddp_mem_rsp_s o_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // responder
    // ********
    logic [2:0] cnt;
    logic [1:0] guard;
    // ack after i_delay cycles, then guard
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= 3'h0;
            guard <= 2'h0;
            o_rsp <= '0;
        end else begin
            o_rsp.ack <= 1'b0;
            o_rsp.own <= ~o_rsp.own;
            if (guard != 2'h0) begin
                guard <= guard - 2'h1;
                cnt <= 3'h0;
            end else if (!i_req.req) begin
                cnt <= 3'h0;
            end else if (cnt >= i_delay) begin
                o_rsp.ack <= 1'b1;
                o_rsp.own <= i_own;
                cnt <= 3'h0;
                guard <= 2'h2;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule

// ---- tb/ddp_dma_bench.sv ----
// bench: self-checking test of the descriptor dma poll, ring base and status block
module ddp_dma_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // bench
    // ********
    localparam int DB = 16;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_ce = 1'b1;
    ddp_pkg::ddp_bus_req_s bus = '0;
    logic [31:0] rdata;
    logic irq;
    ddp_pkg::ddp_mem_req_s txm, rxm;
    ddp_pkg::ddp_mem_rsp_s txr, rxr;
    logic tx_own = 1'b0, rx_own = 1'b0;
    logic fill = 1'b0, fdone = 1'b0, fstart = 1'b0, fend = 1'b0, berr = 1'b0;
    logic [2:0] bkind = 3'h0;
    logic [2:0] dly = 3'h2;
    int n_errors = 0;
    int checks = 0;
    int n_txa = 0, n_rxa = 0, txc = 0, rxc = 0, kind = 0;
    logic [13:0] ev = 14'h0000;
    logic [16:0] msk = 17'h1_ffff;
    logic [31:0] tb, rb, v;
    logic [32:0] exp_tx[$], exp_rx[$];
    always #5 i_clk = ~i_clk;
    ddp_dma #(.DESC_BYTES(DB)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
        .i_bus(bus), .o_rdata(rdata), .o_irq(irq), .o_tx_mem(txm), .i_tx_mem(txr),
        .o_rx_mem(rxm), .i_rx_mem(rxr), .i_tx_fill_done(fill), .i_tx_frame_done(fdone),
        .i_rx_frame_start(fstart), .i_rx_frame_end(fend), .i_bus_err(berr),
        .i_bus_err_kind(bkind));
    ddp_mem_model u_txmem (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(txm), .i_own(tx_own),
        .i_delay(dly), .o_rsp(txr));
    ddp_mem_model u_rxmem (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(rxm), .i_own(rx_own),
        .i_delay(dly), .o_rsp(rxr));
    task chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // compare each answered access
    always @(negedge i_clk) begin
        if (txr.ack === 1'b1) begin
            n_txa++;
            chk({txm.wr, txm.addr}, exp_tx.pop_front());
        end
        if (rxr.ack === 1'b1) begin
            n_rxa++;
            chk({rxm.wr, rxm.addr}, exp_rx.pop_front());
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1 chk({1'b0, rdata}, {1'b0, e});
    endtask
    task pulse(input int w);
        @(posedge i_clk);
        case (w)
            0: fill <= 1'b1;
            1: fdone <= 1'b1;
            2: fstart <= 1'b1;
            3: fend <= 1'b1;
            default: begin
                berr <= 1'b1;
                bkind <= kind[2:0];
            end
        endcase
        @(posedge i_clk);
        {fill, fdone, fstart, fend, berr} <= 5'h00;
    endtask
    // expected status word
    task cst();
        logic [31:0] e;
        logic [16:0] f;
        f = {|(ev & ddp_pkg::NORM_EVENTS), |(ev & ddp_pkg::ABN_EVENTS), 1'b0, ev};
        e = {6'h00, kind[2:0], txc[2:0], rxc[2:0], f};
        #1 chk({32'h0, irq}, {32'h0, |(f & msk)});
        rchk(ddp_pkg::STATUS_OFS, e);
        ev = 14'h0000;
    endtask
    task wack(input bit r, input int n);
        int k;
        k = 0;
        while ((r ? n_rxa : n_txa) < n && k < 300) begin
            @(posedge i_clk);
            k++;
        end
        chk({32'h0, k >= 300}, 33'h0);
        repeat (2) @(posedge i_clk);
    endtask
    task tally_and_finish();
        $display("counts: checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        n_errors++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end
    initial begin
        v = $urandom(32'h6583);
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rchk(ddp_pkg::TX_POLL_OFS, ddp_pkg::POLL_RST);
        rchk(ddp_pkg::RX_POLL_OFS, ddp_pkg::POLL_RST);
        rchk(ddp_pkg::MASK_OFS, 32'h0000_0000);
        wr(8'h04, $urandom);
        rchk(8'h04, 32'h0000_0000);
        cst();
        tb = $urandom;
        rb = $urandom;
        wr(ddp_pkg::TX_BASE_OFS, tb | 32'h0000_0003);
        wr(ddp_pkg::RX_BASE_OFS, rb | 32'h0000_0003);
        tb[1:0] = 2'h0;
        rb[1:0] = 2'h0;
        rchk(ddp_pkg::TX_BASE_OFS, tb);
        rchk(ddp_pkg::RX_BASE_OFS, rb);
        wr(ddp_pkg::MASK_OFS, {15'h0000, msk});
        $display("test registers done");
        dly <= 3'h2 + 3'($urandom % 5);
        exp_tx.push_back({1'b0, tb});
        wr(ddp_pkg::CTRL_OFS, 32'h0000_0001);
        txc = 1;
        cst();
        wack(0, 1);
        txc = 6;
        ev[2] = 1'b1;
        wr(ddp_pkg::MASK_OFS, 32'h0000_0000);
        #1 chk({32'h0, irq}, 33'h0);
        wr(ddp_pkg::MASK_OFS, {15'h0000, msk});
        cst();
        tx_own = 1'b1;
        v = $urandom;
        exp_tx.push_back({1'b0, tb});
        wr(ddp_pkg::TX_POLL_OFS, v);
        txc = 1;
        cst();
        wack(0, 2);
        txc = 3;
        cst();
        rchk(ddp_pkg::TX_POLL_OFS, v);
        pulse(0);
        txc = 2;
        cst();
        exp_tx.push_back({1'b1, tb});
        exp_tx.push_back({1'b0, tb + DB});
        pulse(1);
        txc = 7;
        cst();
        wack(0, 4);
        txc = 3;
        ev[0] = 1'b1;
        wr(ddp_pkg::STATUS_OFS, 32'h0000_0001);
        ev[0] = 1'b0;
        cst();
        $display("test transmit done");
        rx_own = 1'b1;
        exp_rx.push_back({1'b0, rb});
        wr(ddp_pkg::CTRL_OFS, 32'h0000_0003);
        rxc = 1;
        cst();
        wack(1, 1);
        rxc = 3;
        v = $urandom;
        wr(ddp_pkg::RX_POLL_OFS, v);
        repeat (4) @(posedge i_clk);
        chk(n_rxa, 33'h1);
        cst();
        rchk(ddp_pkg::RX_POLL_OFS, v);
        pulse(2);
        rxc = 7;
        cst();
        rx_own = 1'b0;
        exp_rx.push_back({1'b1, rb});
        exp_rx.push_back({1'b0, rb + DB});
        pulse(3);
        rxc = 5;
        cst();
        wack(1, 3);
        rxc = 4;
        ev[7:6] = 2'h3;
        cst();
        pulse(2);
        rxc = 6;
        cst();
        pulse(3);
        rxc = 4;
        cst();
        rx_own = 1'b1;
        exp_rx.push_back({1'b0, rb + DB});
        wr(ddp_pkg::RX_POLL_OFS, $urandom);
        wack(1, 4);
        rxc = 3;
        cst();
        wr(ddp_pkg::CTRL_OFS, 32'h0000_0000);
        txc = 0;
        rxc = 0;
        ev[1] = 1'b1;
        ev[8] = 1'b1;
        // stop flags land one edge after the run bits drop
        @(posedge i_clk);
        cst();
        $display("test receive done");
        for (int k = 0; k < 3; k++) begin
            kind = k;
            pulse(4);
            ev[13] = 1'b1;
            cst();
            #1 chk({32'h0, irq}, 33'h0);
            wr(ddp_pkg::CTRL_OFS, 32'h0000_0003);
            repeat (4) @(posedge i_clk);
            #1 chk({31'h0, txm.req, rxm.req}, 33'h0);
            wr(ddp_pkg::CTRL_OFS, 32'h0000_0004);
            kind = 0;
            cst();
        end
        $display("test bus fault done");
        tally_and_finish();
    end
endmodule
